// ===== duart_host_model.sv
`timescale 1ns/1ns

module duart_host_model (
    input  wire logic       ref_clk,
    output logic      [3:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // bus idles with both strobes low
    initial begin
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // one-cycle write; data lines scrambled once released
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
        @(negedge ref_clk);
    endtask
    // one-cycle read; data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
endmodule

// ===== duart_status_irq_port_pkg.sv
package duart_status_irq_port_pkg;
    // one register byte
    typedef logic [7:0] byte_t;
    // carried error flags: break, framing, parity
    typedef logic [2:0] err_t;
    // pin 3 function select codes
    typedef enum logic [1:0] {
        PIN3_LATCH   = 2'b00,
        PIN3_COUNTER = 2'b01,
        PIN3_TXCLK_B = 2'b10,
        PIN3_RXCLK_B = 2'b11
    } pin3_sel_e;
    // pin 2 function select codes
    typedef enum logic [1:0] {
        PIN2_LATCH     = 2'b00,
        PIN2_TXCLK16_A = 2'b01,
        PIN2_TXCLK_A   = 2'b10,
        PIN2_RXCLK_A   = 2'b11
    } pin2_sel_e;
endpackage

// ===== duart_status_irq_port_regs.sv
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "duart_status_irq_port_regs.svh"

module duart_status_irq_port_regs
    import duart_status_irq_port_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        rx_push_a,
    input  wire logic [7:0]  rx_char_a,
    input  wire logic [2:0]  rx_err_a,
    input  wire logic        rx_push_b,
    input  wire logic [7:0]  rx_char_b,
    input  wire logic [2:0]  rx_err_b,
    input  wire logic        rx_reset_a,
    input  wire logic        rx_reset_b,
    input  wire logic        error_mode_a,
    input  wire logic        error_mode_b,
    input  wire logic        rx_int_select_a,
    input  wire logic        rx_int_select_b,
    input  wire logic        overrun_a,
    input  wire logic        overrun_b,
    input  wire logic        transmitter_empty_a,
    input  wire logic        transmitter_empty_b,
    input  wire logic        chan_a_transmit_ready,
    input  wire logic        chan_b_transmit_ready,
    input  wire logic        break_change_a,
    input  wire logic        break_change_b,
    input  wire logic        counter_ready,
    input  wire logic        counter_output,
    input  wire logic        chan_a_transmit_clock,
    input  wire logic        chan_a_transmit_clock16,
    input  wire logic        chan_a_receive_clock,
    input  wire logic        chan_b_transmit_clock,
    input  wire logic        chan_b_receive_clock,
    input  wire logic [3:0]  input_pins,
    output logic      [7:0]  output_pins,
    output logic             brg_set_select,
    output logic      [2:0]  counter_mode,
    output logic      [15:0] counter_preset,
    output logic             irq
);

    // per-channel views of the receive side
    logic [1:0]       push;                 // character arrives
    logic [7:0]       push_char [2];        // arriving character
    err_t             push_err  [2];        // arriving flags
    logic [1:0]       pop;                  // host reads holding register
    logic [1:0]       err_reset;            // error reset command or receiver reset
    logic [1:0]       block_mode;           // accumulate errors
    logic [1:0]       rx_ready;             // fifo not empty
    logic [1:0]       rx_full;              // fifo full
    logic [1:0]       rx_int_src;           // selected receive interrupt source
    logic [7:0]       head_char [2];        // character at fifo head
    err_t             head_err  [2];        // flags at fifo head
    byte_t            line_status [2];      // assembled status byte

    // control and capture registers
    byte_t            latch_r;              // output latch
    byte_t            func_sel_r;           // output function select
    byte_t            aux_r;                // auxiliary control
    byte_t            mask_r;               // interrupt mask
    byte_t            preset_high_r;        // counter preset upper byte
    byte_t            preset_low_r;         // counter preset lower byte
    logic [3:0]       ip_meta_r;            // first synchroniser stage
    logic [3:0]       ip_sync_r;            // second synchroniser stage
    logic [3:0]       ip_prev_r;            // level one cycle ago
    logic [3:0]       ip_delta_r;           // sticky change bits
    logic             ip_change_r;          // sticky input change event
    logic             brk_a_r;              // sticky break change A
    logic             brk_b_r;              // sticky break change B
    logic             ctr_r;                // sticky counter ready
    byte_t            irq_status;           // assembled interrupt byte
    byte_t            rdata_r;              // read data register

    // decoded strobes
    wire              wr_aux      = reg_wr && (reg_addr == `OFF_CAPTURE_AUX);
    wire              wr_mask     = reg_wr && (reg_addr == `OFF_IRQ_STAT);
    wire              wr_high     = reg_wr && (reg_addr == `OFF_PRESET_HIGH);
    wire              wr_low      = reg_wr && (reg_addr == `OFF_PRESET_LOW);
    wire              wr_func     = reg_wr && (reg_addr == `OFF_PINS_FUNC);
    wire              wr_set      = reg_wr && (reg_addr == `OFF_LATCH_SET);
    wire              wr_clr      = reg_wr && (reg_addr == `OFF_LATCH_CLR);
    wire              wr_irq_clr  = reg_wr && (reg_addr == `OFF_IRQ_CLEAR);
    wire              rd_capture  = reg_rd && (reg_addr == `OFF_CAPTURE_AUX);
    wire              err_cmd     = reg_wr && (reg_wdata[7:4] == `CMD_ERROR_RESET);
    wire              err_cmd_a   = err_cmd && (reg_addr == `OFF_COMMAND_A);
    wire              err_cmd_b   = err_cmd && (reg_addr == `OFF_COMMAND_B);
    wire [3:0]        ip_edge     = ip_sync_r ^ ip_prev_r;
    wire              ip_event    = |(ip_edge & aux_r[3:0]);

    // gather channel signals into arrays
    assign push[0]      = rx_push_a;
    assign push[1]      = rx_push_b;
    assign push_char[0] = rx_char_a;
    assign push_char[1] = rx_char_b;
    assign push_err[0]  = rx_err_a;
    assign push_err[1]  = rx_err_b;
    assign pop[0]       = reg_rd && (reg_addr == `OFF_HOLD_A) && rx_ready[0];
    assign pop[1]       = reg_rd && (reg_addr == `OFF_HOLD_B) && rx_ready[1];
    assign err_reset[0] = err_cmd_a || rx_reset_a;
    assign err_reset[1] = err_cmd_b || rx_reset_b;
    assign block_mode   = {error_mode_b, error_mode_a};

    // receive fifo with carried error flags, one per channel
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [7:0]            char_mem_r [4];  // stored characters
            err_t                  err_mem_r  [4];  // flags stored beside them
            logic [`RX_PTR_W-1:0]  rd_ptr_r;        // head index
            logic [`RX_PTR_W-1:0]  wr_ptr_r;        // tail index
            logic [2:0]            count_r;         // entries held
            err_t                  accum_r;         // block mode accumulation
            wire                   do_push = push[ch] && !rx_full[ch];
            wire [2:0]             count_nxt = count_r
                                             + {2'b00, do_push}
                                             - {2'b00, pop[ch]};

            assign rx_ready[ch]  = (count_r != 3'h0);
            assign rx_full[ch]   = (count_r == `RX_DEPTH);
            assign head_char[ch] = char_mem_r[rd_ptr_r];
            assign head_err[ch]  = rx_ready[ch] ? err_mem_r[rd_ptr_r] : 3'h0;

            // pointer and count bookkeeping
            always_ff @(posedge ref_clk) begin
                if (!resetn || (ch == 0 ? rx_reset_a : rx_reset_b)) begin
                    rd_ptr_r <= '0;
                    wr_ptr_r <= '0;
                    count_r  <= 3'h0;
                end else begin
                    if (do_push) begin
                        wr_ptr_r <= wr_ptr_r + 2'h1;
                    end
                    if (pop[ch]) begin
                        rd_ptr_r <= rd_ptr_r + 2'h1;
                    end
                    count_r <= count_nxt;
                end
            end

            // storage: flags written together with the character
            for (genvar e = 0; e < 4; e++) begin : g_entry
                always_ff @(posedge ref_clk) begin
                    if (!resetn) begin
                        char_mem_r[e] <= 8'h00;
                        err_mem_r[e]  <= 3'h0;
                    end else if (do_push && (wr_ptr_r == 2'(e))) begin
                        char_mem_r[e] <= push_char[ch];
                        err_mem_r[e]  <= push_err[ch];
                    end else if (err_reset[ch]) begin
                        err_mem_r[e]  <= 3'h0;
                    end
                end
            end

            // block mode keeps flags of characters already popped
            always_ff @(posedge ref_clk) begin
                if (!resetn || err_reset[ch]) begin
                    accum_r <= 3'h0;
                end else if (pop[ch] && block_mode[ch]) begin
                    accum_r <= accum_r | head_err[ch];
                end
            end

            // status byte: head flags over live bits
            assign line_status[ch] = {
                head_err[ch] | (block_mode[ch] ? accum_r : 3'h0),
                (ch == 0) ? overrun_a : overrun_b,
                (ch == 0) ? transmitter_empty_a : transmitter_empty_b,
                (ch == 0) ? chan_a_transmit_ready : chan_b_transmit_ready,
                rx_full[ch],
                rx_ready[ch]
            };

            // receive interrupt source selection
            assign rx_int_src[ch] = (ch == 0 ? rx_int_select_a : rx_int_select_b)
                                  ? rx_full[ch] : rx_ready[ch];
        end
    endgenerate

    // write-only control bytes
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            func_sel_r    <= `RESET_BYTE;
            aux_r         <= `RESET_BYTE;
            mask_r        <= `RESET_BYTE;
            preset_high_r <= `RESET_BYTE;
            preset_low_r  <= `RESET_BYTE;
        end else begin
            if (wr_func) func_sel_r    <= reg_wdata;
            if (wr_aux)  aux_r         <= reg_wdata;
            if (wr_mask) mask_r        <= reg_wdata;
            if (wr_high) preset_high_r <= reg_wdata;
            if (wr_low)  preset_low_r  <= reg_wdata;
        end
    end

    // output latch: individual set and reset
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            latch_r <= `RESET_BYTE;
        end else if (wr_set) begin
            latch_r <= latch_r | reg_wdata;
        end else if (wr_clr) begin
            latch_r <= latch_r & ~reg_wdata;
        end
    end

    // input pin synchroniser and previous level
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ip_meta_r <= 4'h0;
            ip_sync_r <= 4'h0;
            ip_prev_r <= 4'h0;
        end else begin
            ip_meta_r <= input_pins;
            ip_sync_r <= ip_meta_r;
            ip_prev_r <= ip_sync_r;
        end
    end

    // change capture: cleared by reading it, a new change wins
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ip_delta_r <= 4'h0;
        end else begin
            ip_delta_r <= (rd_capture ? 4'h0 : ip_delta_r) | ip_edge;
        end
    end

    // sticky interrupt events, set beats clear
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ip_change_r <= 1'b0;
            brk_a_r     <= 1'b0;
            brk_b_r     <= 1'b0;
            ctr_r       <= 1'b0;
        end else begin
            ip_change_r <= ip_event | (ip_change_r & ~rd_capture
                         & ~(wr_irq_clr & reg_wdata[`IRQ_INPUT_CHANGE]));
            brk_b_r     <= break_change_b
                         | (brk_b_r & ~(wr_irq_clr & reg_wdata[`IRQ_BREAK_B]));
            ctr_r       <= counter_ready
                         | (ctr_r & ~(wr_irq_clr & reg_wdata[`IRQ_COUNTER]));
            brk_a_r     <= break_change_a
                         | (brk_a_r & ~(wr_irq_clr & reg_wdata[`IRQ_BREAK_A]));
        end
    end

    // interrupt byte in documented bit order
    assign irq_status = {ip_change_r, brk_b_r, rx_int_src[1], chan_b_transmit_ready,
                         ctr_r, brk_a_r, rx_int_src[0], chan_a_transmit_ready};
    assign irq        = |(irq_status & mask_r);

    // read mux
    wire [7:0] rd_mux =
        (reg_addr == `OFF_STATUS_A)    ? line_status[0] :
        (reg_addr == `OFF_STATUS_B)    ? line_status[1] :
        (reg_addr == `OFF_HOLD_A)      ? head_char[0] :
        (reg_addr == `OFF_HOLD_B)      ? head_char[1] :
        (reg_addr == `OFF_CAPTURE_AUX) ? {ip_delta_r, ip_sync_r} :
        (reg_addr == `OFF_IRQ_STAT)    ? irq_status :
        (reg_addr == `OFF_PINS_FUNC)   ? {4'h0, ip_sync_r} :
                                         8'h00;

    // read data stand one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_r;

    // output pin functions; latch-driven pins are inverted
    wire pin3_src = (func_sel_r[3:2] == PIN3_COUNTER) ? counter_output :
                    (func_sel_r[3:2] == PIN3_TXCLK_B) ? chan_b_transmit_clock :
                                                        chan_b_receive_clock;
    wire pin2_src = (func_sel_r[1:0] == PIN2_TXCLK16_A) ? chan_a_transmit_clock16 :
                    (func_sel_r[1:0] == PIN2_TXCLK_A)   ? chan_a_transmit_clock :
                                                          chan_a_receive_clock;
    assign output_pins[7] = func_sel_r[7] ? chan_b_transmit_ready : ~latch_r[7];
    assign output_pins[6] = func_sel_r[6] ? chan_a_transmit_ready : ~latch_r[6];
    assign output_pins[5] = func_sel_r[5] ? rx_int_src[1] : ~latch_r[5];
    assign output_pins[4] = func_sel_r[4] ? rx_int_src[0] : ~latch_r[4];
    assign output_pins[3] = (func_sel_r[3:2] == PIN3_LATCH) ? ~latch_r[3] : pin3_src;
    assign output_pins[2] = (func_sel_r[1:0] == PIN2_LATCH) ? ~latch_r[2] : pin2_src;
    assign output_pins[1:0] = ~latch_r[1:0];

    // auxiliary and preset outputs
    assign brg_set_select = aux_r[`AUX_BRG_SET_BIT];
    assign counter_mode   = aux_r[6:4];
    assign counter_preset = {preset_high_r, preset_low_r};

endmodule

// ===== duart_status_irq_port_regs.svh
`ifndef DUART_STATUS_IRQ_PORT_REGS_SVH
`define DUART_STATUS_IRQ_PORT_REGS_SVH

// register offsets on the 4-bit port
`define OFF_STATUS_A     4'h1
`define OFF_COMMAND_A    4'h2
`define OFF_HOLD_A       4'h3
`define OFF_CAPTURE_AUX  4'h4
`define OFF_IRQ_STAT     4'h5
`define OFF_PRESET_HIGH  4'h6
`define OFF_PRESET_LOW   4'h7
`define OFF_STATUS_B     4'h9
`define OFF_COMMAND_B    4'hA
`define OFF_HOLD_B       4'hB
`define OFF_IRQ_CLEAR    4'hC
`define OFF_PINS_FUNC    4'hD
`define OFF_LATCH_SET    4'hE
`define OFF_LATCH_CLR    4'hF

// command code in the upper nibble for error reset
`define CMD_ERROR_RESET  4'h4

// receive fifo depth and pointer width
`define RX_DEPTH         3'h4
`define RX_PTR_W         2

// auxiliary control fields
`define AUX_BRG_SET_BIT  7

// interrupt status bit positions
`define IRQ_INPUT_CHANGE 7
`define IRQ_BREAK_B      6
`define IRQ_RX_B         5
`define IRQ_TX_B         4
`define IRQ_COUNTER      3
`define IRQ_BREAK_A      2
`define IRQ_RX_A         1
`define IRQ_TX_A         0

// reset values of the control bytes
`define RESET_BYTE       8'h00

`endif

// ===== duart_status_irq_port_regs_assertions.sv
`timescale 1ns/1ns
`include "duart_status_irq_port_regs.svh"

module duart_status_irq_port_regs_chk (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        chan_a_transmit_ready,
    input wire logic        chan_b_transmit_ready,
    input wire logic        counter_output,
    input wire logic        chan_b_transmit_clock,
    input wire logic        chan_b_receive_clock,
    input wire logic [7:0]  output_pins,
    input wire logic        brg_set_select,
    input wire logic [15:0] counter_preset,
    input wire logic        irq
);
    logic [7:0] sel_r;   // shadow of the pin function select
    logic [7:0] lat_r;   // shadow of the output latch
    logic [7:0] msk_r;   // shadow of the interrupt mask
    logic       wr_aux;  // write to auxiliary control
    logic       wr_hi;   // write to preset upper byte
    logic       wr_lo;   // write to preset lower byte
    logic [1:0] p3_sel;  // pin 3 code
    logic       p3_exp;  // expected pin 3 level

    assign wr_aux = reg_wr && reg_addr == `OFF_CAPTURE_AUX;
    assign wr_hi  = reg_wr && reg_addr == `OFF_PRESET_HIGH;
    assign wr_lo  = reg_wr && reg_addr == `OFF_PRESET_LOW;
    assign p3_sel = sel_r[3:2];
    assign p3_exp = p3_sel == 2'h0 ? ~lat_r[3] : p3_sel == 2'h1 ? counter_output :
                    p3_sel == 2'h2 ? chan_b_transmit_clock : chan_b_receive_clock;

    // shadows follow the host writes; clear wins as it comes last
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sel_r <= 8'h00;
            lat_r <= 8'h00;
            msk_r <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `OFF_PINS_FUNC) sel_r <= reg_wdata;
            if (reg_wr && reg_addr == `OFF_LATCH_SET) lat_r <= lat_r | reg_wdata;
            if (reg_wr && reg_addr == `OFF_LATCH_CLR) lat_r <= lat_r & ~reg_wdata;
            if (reg_wr && reg_addr == `OFF_IRQ_STAT) msk_r <= reg_wdata;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_pin7_mux: assert property (
        output_pins[7] == (sel_r[7] ? chan_b_transmit_ready : ~lat_r[7]))
        else $error("pin 7 source wrong");
    chk_pin3_mux: assert property (output_pins[3] == p3_exp)
        else $error("pin 3 source wrong");
    chk_latch_pins: assert property (output_pins[1:0] == ~lat_r[1:0])
        else $error("latch pins not inverted");
    chk_brg_select: assert property (wr_aux |=> brg_set_select == $past(reg_wdata[7]))
        else $error("baud set select wrong");
    chk_preset_high: assert property (wr_hi |=> counter_preset[15:8] == $past(reg_wdata))
        else $error("preset upper byte wrong");
    chk_preset_low: assert property (wr_lo |=> counter_preset[7:0] == $past(reg_wdata))
        else $error("preset lower byte wrong");
    chk_irq_masked: assert property (msk_r == 8'h00 |-> !irq)
        else $error("irq with empty mask");
    chk_status_live: assert property (
        reg_rd && reg_addr == `OFF_STATUS_A |=> reg_rdata[2] == $past(chan_a_transmit_ready))
        else $error("status transmit ready wrong");
endmodule

bind duart_status_irq_port_regs duart_status_irq_port_regs_chk i_chk (
    .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .chan_a_transmit_ready, .chan_b_transmit_ready, .counter_output,
    .chan_b_transmit_clock, .chan_b_receive_clock, .output_pins,
    .brg_set_select, .counter_preset, .irq
);

// ===== test_duart_status_irq_port_regs.sv
`timescale 1ns/1ns
`include "duart_status_irq_port_regs.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end

module test_duart_status_irq_port_regs;
    import duart_status_irq_port_pkg::*;
    logic ref_clk = 0, resetn = 0, rx_push_a = 0, rx_push_b = 0, rx_reset_b = 0;
    logic error_mode_a = 0, error_mode_b = 0, rx_int_select_a = 0, rx_int_select_b = 0;
    logic overrun_a = 1, overrun_b = 0, transmitter_empty_a = 1, transmitter_empty_b = 0;
    logic chan_a_transmit_ready = 1, chan_b_transmit_ready = 0;
    logic counter_output = 1, chan_a_transmit_clock = 0;
    logic [3:0]  ev = 4'h0;   // event pulses: receiver reset a, break a, break b, counter
    wire rx_reset_a = ev[0], break_change_a = ev[1];
    wire break_change_b = ev[2], counter_ready = ev[3];
    logic chan_a_transmit_clock16 = 1, chan_a_receive_clock = 1, chan_b_transmit_clock = 0;
    logic chan_b_receive_clock = 1, reg_wr, reg_rd, brg_set_select, irq;
    logic [7:0]  rx_char_a = 8'h00, rx_char_b = 8'h00, reg_wdata, reg_rdata, output_pins, d;
    logic [2:0]  rx_err_a = 3'h0, rx_err_b = 3'h0, counter_mode;
    logic [3:0]  input_pins = 4'h0, reg_addr;
    logic [15:0] counter_preset;
    int          n_mismatch = 0, cmp_count = 0;

    duart_host_model i_host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    duart_status_irq_port_regs i_dut (
        .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_push_a,
        .rx_char_a, .rx_err_a, .rx_push_b, .rx_char_b, .rx_err_b, .rx_reset_a, .rx_reset_b,
        .error_mode_a, .error_mode_b, .rx_int_select_a, .rx_int_select_b, .overrun_a,
        .overrun_b, .transmitter_empty_a, .transmitter_empty_b, .chan_a_transmit_ready,
        .chan_b_transmit_ready, .break_change_a, .break_change_b, .counter_ready,
        .counter_output, .chan_a_transmit_clock, .chan_a_transmit_clock16,
        .chan_a_receive_clock, .chan_b_transmit_clock, .chan_b_receive_clock, .input_pins,
        .output_pins, .brg_set_select, .counter_mode, .counter_preset, .irq);

    // 10 MHz clock
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // receive engine delivers one character to channel a
    task automatic push_a(input logic [7:0] c, input logic [2:0] e);
        @(posedge ref_clk);
        rx_push_a <= 1'b1;
        rx_char_a <= c;
        rx_err_a  <= e;
        @(posedge ref_clk);
        rx_push_a <= 1'b0;
        rx_char_a <= ~c;
    endtask
    // one-cycle pulse on the event inputs picked by m
    task automatic pulse(input logic [3:0] m);
        @(posedge ref_clk);
        ev <= m;
        @(posedge ref_clk);
        ev <= 4'h0;
        @(negedge ref_clk);
    endtask
    task automatic t_reset;
        `CHK("pins", 8'hFF, output_pins)
        `CHK("irq", 1'b0, irq)
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("status live", 8'h1C, d)
        @(posedge ref_clk);
        overrun_a <= 1'b0;
        transmitter_empty_a <= 1'b0;
        $display("test reset done");
    endtask
    task automatic t_fifo;
        push_a(8'h41, 3'h4);
        push_a(8'h42, 3'h1);
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("status head", 8'h85, d)
        i_host.rd(`OFF_IRQ_STAT, d);
        `CHK("isr ready src", 8'h03, d)
        @(posedge ref_clk);
        rx_int_select_a <= 1'b1;
        i_host.rd(`OFF_IRQ_STAT, d);
        `CHK("isr full src", 8'h01, d)
        @(posedge ref_clk);
        rx_int_select_a <= 1'b0;
        i_host.rd(`OFF_HOLD_A, d);
        `CHK("char 1", 8'h41, d)
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("status next", 8'h25, d)
        i_host.rd(`OFF_HOLD_A, d);
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("status empty", 8'h04, d)
        for (int i = 0; i < 5; i++) push_a(8'(i), 3'h0);
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("status full", 8'h07, d)
        for (int i = 0; i < 4; i++) begin
            i_host.rd(`OFF_HOLD_A, d);
            `CHK("fifo char", 8'(i), d)
        end
        $display("test fifo done");
    endtask
    task automatic t_block;
        @(posedge ref_clk);
        error_mode_a <= 1'b1;
        push_a(8'h50, 3'h2);
        push_a(8'h51, 3'h1);
        i_host.rd(`OFF_HOLD_A, d);
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("block accum", 8'h65, d)
        i_host.rd(`OFF_HOLD_A, d);
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("block kept", 8'h64, d)
        i_host.wr(`OFF_COMMAND_A, 8'h40);
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("error reset", 8'h04, d)
        push_a(8'h52, 3'h4);
        i_host.wr(`OFF_COMMAND_A, 8'h40);
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("fifo flags reset", 8'h05, d)
        i_host.rd(`OFF_HOLD_A, d);
        push_a(8'h53, 3'h4);
        i_host.rd(`OFF_HOLD_A, d);
        pulse(4'h1);
        i_host.rd(`OFF_STATUS_A, d);
        `CHK("receiver reset", 8'h04, d)
        @(posedge ref_clk);
        error_mode_a <= 1'b0;
        $display("test block done");
    endtask
    task automatic t_pins;
        i_host.wr(`OFF_LATCH_SET, 8'hFF);
        `CHK("latch set", 8'h00, output_pins)
        i_host.wr(`OFF_LATCH_CLR, 8'h5A);
        `CHK("latch clear", 8'h5A, output_pins)
        @(posedge ref_clk);
        chan_b_transmit_ready <= 1'b1;
        i_host.wr(`OFF_PINS_FUNC, 8'hF0);
        `CHK("pins 7:4", 8'hCA, output_pins)
        @(posedge ref_clk);
        rx_push_b <= 1'b1;
        rx_char_b <= 8'h77;
        @(posedge ref_clk);
        rx_push_b <= 1'b0;
        @(negedge ref_clk);
        `CHK("pin 5 ready b", 8'hEA, output_pins)
        i_host.rd(`OFF_STATUS_B, d);
        `CHK("status b", 8'h05, d)
        i_host.rd(`OFF_HOLD_B, d);
        `CHK("char b", 8'h77, d)
        for (int i = 0; i < 4; i++) begin
            i_host.wr(`OFF_PINS_FUNC, {4'h0, 2'(i), 2'(i)});
            `CHK("pins 3:2", 2'(8'hCE >> (2 * i)), output_pins[3:2])
        end
        $display("test pins done");
    endtask
    task automatic t_aux_irq;
        i_host.wr(`OFF_CAPTURE_AUX, 8'hD0);
        `CHK("brg select", 1'b1, brg_set_select)
        `CHK("counter mode", 3'h5, counter_mode)
        i_host.wr(`OFF_PRESET_HIGH, 8'hAB);
        i_host.wr(`OFF_PRESET_LOW, 8'hCD);
        `CHK("preset", 16'hABCD, counter_preset)
        i_host.wr(`OFF_IRQ_STAT, 8'h08);
        `CHK("irq masked", 1'b0, irq)
        pulse(4'h8);
        `CHK("irq counter", 1'b1, irq)
        i_host.rd(`OFF_IRQ_STAT, d);
        `CHK("isr counter", 8'h19, d)
        i_host.wr(`OFF_IRQ_CLEAR, 8'h08);
        pulse(4'h2);
        pulse(4'h4);
        `CHK("irq cleared", 1'b0, irq)
        i_host.rd(`OFF_IRQ_STAT, d);
        `CHK("isr breaks", 8'h55, d)
        i_host.rd(4'h8, d);
        `CHK("unmapped", 8'h00, d)
        i_host.wr(`OFF_IRQ_STAT, 8'h80);
        i_host.wr(`OFF_CAPTURE_AUX, 8'h8F);
        @(posedge ref_clk);
        input_pins <= 4'h5;
        repeat (5) @(negedge ref_clk);
        `CHK("irq input", 1'b1, irq)
        i_host.rd(`OFF_CAPTURE_AUX, d);
        `CHK("capture", 8'h55, d)
        `CHK("irq read clear", 1'b0, irq)
        i_host.rd(`OFF_CAPTURE_AUX, d);
        `CHK("capture level", 8'h05, d)
        $display("test aux irq done");
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles of the tests
    initial begin
        #1000000;
        n_mismatch++;
        summarize();
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        t_reset();
        t_fifo();
        t_block();
        t_pins();
        t_aux_irq();
        summarize();
    end
endmodule
